// ===== src/rfsi_defines.vh
// register offsets, field positions, reset values and timing counts for the status block
`ifndef RFSI_DEFINES_VH
`define RFSI_DEFINES_VH

`define RFSI_ADDR_W          6
`define RFSI_OFF_CHIP_CTRL   6'h00
`define RFSI_OFF_PROTO_CTRL  6'h01
`define RFSI_OFF_SPECIAL     6'h10
`define RFSI_OFF_STATUS      6'h0C
`define RFSI_OFF_MASK        6'h0D
`define RFSI_OFF_COLPOS      6'h0E
`define RFSI_OFF_LEVEL       6'h0F

`define RFSI_BIT_TX          7
`define RFSI_BIT_RXSTART     6
`define RFSI_BIT_FIFO        5
`define RFSI_BIT_ERR1        4
`define RFSI_BIT_ERR2        3
`define RFSI_BIT_ERR3        2
`define RFSI_BIT_COL         1
`define RFSI_BIT_NORESP      0

`define RFSI_CHIP_SWAP_BIT   3
`define RFSI_PROTO_NOCRC_BIT 7
`define RFSI_SPEC_COL6_BIT   0
`define RFSI_LEVEL_OSC_BIT   6

`define RFSI_STATUS_RST      8'h00
`define RFSI_MASK_RST        6'h3E
`define RFSI_COLPOS_RST      10'h000

`define RFSI_OSC_SETTLE_NS   200000
`define RFSI_CLK_PERIOD_NS   4
`define RFSI_OSC_SETTLE_CYC  (`RFSI_OSC_SETTLE_NS / `RFSI_CLK_PERIOD_NS)

`endif

// ===== src/rfsi_status_irq.v
// status, interrupt mask, collision position and signal level registers of the rf front end
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
//
// Notes on behaviour
// - status clears at reset, disable, protocol write
// - status read clears it and drops irq
// - tx flag at start, irq at tx end
// - rx start flag at sof, irq at end
// - fifo flag for level events
// - crc error only when crc check enabled
// - parity bit3, framing bit2 in reader
// - collision when pulses exceed 6 or 7
// - no-response flag, also next slot ready
// - during tx only tx and fifo change
// - during rx only rx start changes
// - nfc: protocol error bit4, sdd bit3
// - nfc: rf field change on bit2
// - nfc: collision avoidance done on bit1
// - nfc: collision avoidance failed on bit0
// - mask enables reset to 0x3E
// - ten-bit collision position, clears on read
// - other protocols report error bit position
// - oscillator stable flag after 200 us
// - main/aux level fields, swap by chip bit
// - peak level latched, reset at tx start
// - each level is 3-bit code
//
`include "rfsi_defines.vh"

module rfsi_status_irq #(
    parameter OSC_SETTLE_CYC = `RFSI_OSC_SETTLE_CYC
) (
    input  wire        clk,
    input  wire        srst,
    input  wire        enable,
    input  wire [5:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    output reg         irq,
    input  wire        nfc_mode,
    input  wire        type_a_mode,
    input  wire        tx_start,
    input  wire        tx_end,
    input  wire        rx_sof,
    input  wire        rx_end,
    input  wire        fifo_level_event,
    input  wire        crc_error,
    input  wire        protocol_error,
    input  wire        parity_error,
    input  wire        framing_error,
    input  wire [3:0]  subcarrier_pulses,
    input  wire        bit_period_end,
    input  wire        no_response_timeout,
    input  wire        next_slot_ready,
    input  wire        sdd_done,
    input  wire        field_change,
    input  wire        col_avoid_done,
    input  wire        col_avoid_fail,
    input  wire        error_event,
    input  wire [9:0]  error_bit_pos,
    input  wire [2:0]  main_receive_input,
    input  wire [2:0]  aux_receive_input,
    output reg         decoder_enable
);

////////////////////////////////////////////////////////////////////////////////

reg  [7:0]  status;
reg  [5:0]  mask;
reg  [9:0]  col_pos;
reg  [2:0]  main_level;
reg  [2:0]  aux_level;
reg         osc_ok;
reg  [17:0] osc_cnt;
reg         tx_busy;
reg         rx_busy;
reg         irq_pend;
reg  [7:0]  chip_ctrl;
reg  [7:0]  proto_ctrl;
reg  [7:0]  special;
reg  [7:0]  next_status;
reg  [7:0]  events;
reg  [7:0]  next_rdata;
reg         next_irq_pend;
reg         next_tx_busy;
reg         next_rx_busy;
reg  [2:0]  next_main_level;
reg  [2:0]  next_aux_level;
reg  [17:0] next_osc_cnt;
reg         next_osc_ok;
reg  [4:0]  rdr_ev;
reg  [4:0]  nfc_ev;
wire [2:0]  main_src;
wire [2:0]  aux_src;
wire [7:0]  level_view;
wire [7:0]  mask_view;

// last count of the settle counter, cut to the counter width on purpose
localparam [17:0] OSC_LAST = OSC_SETTLE_CYC - 1;
// phase masks: tx keeps tx and fifo bits, rx keeps only rx start
localparam [7:0]  TX_KEEP  = 8'hA0;
localparam [7:0]  RX_KEEP  = 8'h40;

// one register select, shared by every read and write strobe
function addr_is;
    input [5:0] a;
    input [5:0] off;
    begin
        addr_is = (a == off);
    end
endfunction

wire clr_all  = srst | ~enable;
wire proto_wr = reg_wr & addr_is(reg_addr, `RFSI_OFF_PROTO_CTRL);
wire chip_wr  = reg_wr & addr_is(reg_addr, `RFSI_OFF_CHIP_CTRL);
wire mask_wr  = reg_wr & addr_is(reg_addr, `RFSI_OFF_MASK);
wire spec_wr  = reg_wr & addr_is(reg_addr, `RFSI_OFF_SPECIAL);
wire stat_rd  = reg_rd & addr_is(reg_addr, `RFSI_OFF_STATUS);
wire mask_rd  = reg_rd & addr_is(reg_addr, `RFSI_OFF_MASK);
wire cpos_rd  = reg_rd & addr_is(reg_addr, `RFSI_OFF_COLPOS);
// phase end: the only point where tx and rx start may raise the line
wire phase_end  = (tx_busy & tx_end) | (rx_busy & rx_end);
wire idle_phase = ~tx_busy & ~rx_busy;
wire crc_on   = ~proto_ctrl[`RFSI_PROTO_NOCRC_BIT];
wire [3:0] col_limit = special[`RFSI_SPEC_COL6_BIT] ? 4'h6 : 4'h7;
wire col_hit  = type_a_mode & bit_period_end & (subcarrier_pulses > col_limit);

// maps a status bit to its enable; tx and rx start always interrupt
function en_of;
    input [2:0] b;
    input [5:0] m;
    begin
        if (b >= 3'h6)
            en_of = 1'b1;
        else
            en_of = m[b];
    end
endfunction

// picks the larger of two 3-bit level codes
function [2:0] peak3;
    input [2:0] a;
    input [2:0] b;
    begin
        peak3 = (a > b) ? a : b;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// event sources per mode

// reader meanings of the low five status bits
always @* begin
    rdr_ev    = 5'h00;
    rdr_ev[4] = crc_error & crc_on;
    rdr_ev[3] = parity_error & type_a_mode;
    rdr_ev[2] = framing_error;
    rdr_ev[1] = col_hit;
    rdr_ev[0] = no_response_timeout | next_slot_ready;
end

// field and emulation meanings of the same bits
always @* begin
    nfc_ev    = 5'h00;
    nfc_ev[4] = protocol_error;
    nfc_ev[3] = sdd_done;
    nfc_ev[2] = field_change;
    nfc_ev[1] = col_avoid_done;
    nfc_ev[0] = col_avoid_fail;
end

// merged view, then gated by the active phase

always @* begin
    events = 8'h00;
    events[`RFSI_BIT_TX]      = tx_start;
    events[`RFSI_BIT_RXSTART] = rx_sof;
    events[`RFSI_BIT_FIFO]    = fifo_level_event;
    events[`RFSI_BIT_ERR1:`RFSI_BIT_NORESP] = nfc_mode ? nfc_ev : rdr_ev;
    // phase gating: tx touches only tx and fifo, rx only rx start
    if (tx_busy | tx_start)
        events = events & TX_KEEP;
    else if (rx_busy)
        events = events & RX_KEEP;
end

////////////////////////////////////////////////////////////////////////////////
// phase tracking; a running tx blocks a late rx start, but an rx sof in the tx start cycle still starts rx

always @* begin
    next_tx_busy = tx_busy;
    next_rx_busy = rx_busy;
    if (tx_start)
        next_tx_busy = 1'b1;
    else if (tx_end)
        next_tx_busy = 1'b0;
    if (rx_sof & ~tx_busy)
        next_rx_busy = 1'b1;
    else if (rx_end)
        next_rx_busy = 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// status register; a same-cycle event survives the read clear

integer i;

always @* begin
    next_status   = stat_rd ? `RFSI_STATUS_RST : status;
    next_status   = next_status | events;
    next_irq_pend = irq_pend & ~stat_rd;
    for (i = 0; i < 8; i = i + 1) begin
        // errors outside a phase raise at once, phase bits wait for phase end
        if (events[i] & (i < 6) & en_of(i[2:0], mask) & idle_phase)
            next_irq_pend = 1'b1;
    end
    if (phase_end)
        next_irq_pend = 1'b1;
    if (proto_wr) begin
        next_status   = `RFSI_STATUS_RST;
        next_irq_pend = 1'b0;
    end
end

always @(posedge clk) begin
    if (clr_all) begin
        status   <= `RFSI_STATUS_RST;
        irq_pend <= 1'b0;
        tx_busy  <= 1'b0;
        rx_busy  <= 1'b0;
    end else begin
        status   <= next_status;
        irq_pend <= next_irq_pend;
        tx_busy  <= next_tx_busy;
        rx_busy  <= next_rx_busy;
    end
end

////////////////////////////////////////////////////////////////////////////////
// configuration registers and collision position

always @(posedge clk) begin
    if (clr_all)
        mask <= `RFSI_MASK_RST;
    else if (mask_wr)
        mask <= reg_wdata[5:0];
end

always @(posedge clk) begin
    if (clr_all)
        chip_ctrl <= 8'h00;
    else if (chip_wr)
        chip_ctrl <= reg_wdata;
end

always @(posedge clk) begin
    if (clr_all)
        proto_ctrl <= 8'h00;
    else if (proto_wr)
        proto_ctrl <= reg_wdata;
end

always @(posedge clk) begin
    if (clr_all)
        special <= 8'h00;
    else if (spec_wr)
        special <= reg_wdata;
end

// capture wins over the read clear so no position is lost
always @(posedge clk) begin
    if (clr_all)
        col_pos <= `RFSI_COLPOS_RST;
    else if (col_hit & ~tx_busy & ~nfc_mode)
        col_pos <= error_bit_pos;
    else if (error_event & ~type_a_mode & ~nfc_mode)
        col_pos <= error_bit_pos;
    else if (cpos_rd)
        col_pos <= `RFSI_COLPOS_RST;
    else if (mask_rd)
        col_pos[9:8] <= 2'b00;
end

////////////////////////////////////////////////////////////////////////////////
// signal levels and oscillator settle

// swap routes which input feeds which field
assign main_src = chip_ctrl[`RFSI_CHIP_SWAP_BIT] ? aux_receive_input
                                                 : main_receive_input;
assign aux_src  = chip_ctrl[`RFSI_CHIP_SWAP_BIT] ? main_receive_input
                                                 : aux_receive_input;

// counter stops at the last count so it cannot wrap and drop the flag
always @* begin
    next_osc_cnt = osc_cnt;
    next_osc_ok  = osc_ok;
    if (osc_cnt >= OSC_LAST)
        next_osc_ok = 1'b1;
    else
        next_osc_cnt = osc_cnt + 18'h00001;
end

// peak hold: levels only rise during a reception, a tx start clears them
always @* begin
    next_main_level = main_level;
    next_aux_level  = aux_level;
    if (tx_start) begin
        next_main_level = 3'h0;
        next_aux_level  = 3'h0;
    end else if (rx_busy | rx_sof) begin
        next_main_level = peak3(main_level, main_src);
        next_aux_level  = peak3(aux_level, aux_src);
    end
end

always @(posedge clk) begin
    if (clr_all) begin
        main_level <= 3'h0;
        aux_level  <= 3'h0;
        osc_cnt    <= 18'h00000;
        osc_ok     <= 1'b0;
    end else begin
        main_level <= next_main_level;
        aux_level  <= next_aux_level;
        osc_cnt    <= next_osc_cnt;
        osc_ok     <= next_osc_ok;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read port and outputs

assign mask_view  = {col_pos[9:8], mask};
assign level_view = {1'b0, osc_ok, aux_level, main_level};

always @* begin
    case (reg_addr)
        `RFSI_OFF_CHIP_CTRL:  next_rdata = chip_ctrl;
        `RFSI_OFF_PROTO_CTRL: next_rdata = proto_ctrl;
        `RFSI_OFF_SPECIAL:    next_rdata = special;
        `RFSI_OFF_STATUS:     next_rdata = status;
        `RFSI_OFF_MASK:       next_rdata = mask_view;
        `RFSI_OFF_COLPOS:     next_rdata = col_pos[7:0];
        `RFSI_OFF_LEVEL:      next_rdata = level_view;
        default:              next_rdata = 8'h00;
    endcase
end

// read data is zero outside the answer cycle so a stray sample reads nothing
always @(posedge clk) begin
    if (srst)
        reg_rdata <= 8'h00;
    else if (reg_rd)
        reg_rdata <= next_rdata;
    else
        reg_rdata <= 8'h00;
end

// line follows the pending flag; disable drops it at once
always @(posedge clk) begin
    if (srst)
        irq <= 1'b0;
    else
        irq <= next_irq_pend & enable;
end

// decoder goes quiet on the tx start cycle itself, not one cycle late
always @(posedge clk) begin
    if (srst)
        decoder_enable <= 1'b0;
    else
        decoder_enable <= enable & ~(tx_busy | tx_start);
end

endmodule

// ===== testbench/rfsi_host_model.sv
// host model driving the register port one access at a time
`timescale 1ns/10ps
module rfsi_host_model (
    input  wire       clk,
    input  wire [7:0] reg_rdata,
    output reg  [5:0] reg_addr,
    output reg  [7:0] reg_wdata,
    output reg        reg_wr,
    output reg        reg_rd
);
    initial begin
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // released bus shows inverted values so a stale address cannot pass as valid
    task wr(input [5:0] a, input [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    // a status read is also the interrupt acknowledge
    task rd(input [5:0] a, output [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        d = reg_rdata;
    endtask
endmodule

// ===== testbench/rfsi_status_irq_properties.sv
// concurrent checks on the ports of the status and interrupt block
`timescale 1ns/10ps
module rfsi_status_irq_chk (
    input wire       clk,
    input wire       srst,
    input wire       enable,
    input wire [5:0] reg_addr,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       irq,
    input wire       tx_start,
    input wire       tx_end,
    input wire       rx_end,
    input wire       decoder_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////////
    status_ack_a: assert property (
        reg_rd && reg_addr == 6'h0C && !tx_end && !rx_end |=> !tx_end && !rx_end |=> !irq)
        else $error("irq stayed up after status read");
    proto_clear_a: assert property (reg_wr && reg_addr == 6'h01 |=> ##1 !irq)
        else $error("irq survived protocol write");
    disable_clear_a: assert property (!enable ##1 !enable |=> !irq)
        else $error("irq up while disabled");
    tx_end_irq_a: assert property (
        tx_end && enable && !reg_rd |=> enable && !reg_rd && !reg_wr |=> irq)
        else $error("no irq two cycles after tx end");
    rx_end_irq_a: assert property (
        rx_end && enable && !reg_rd |=> enable && !reg_rd && !reg_wr |=> irq)
        else $error("no irq two cycles after rx end");
    decoder_off_a: assert property (tx_start |=> !decoder_enable)
        else $error("decoder on during transmit");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read answer");
    unmapped_rd_a: assert property (reg_rd && reg_addr == 6'h3F |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    // irq is a level: only a read, a write or disable may drop it
    irq_holds_a: assert property (
        irq && !$past(reg_rd) && !$past(reg_wr) && $past(enable) && !reg_rd && !reg_wr
        && enable |=> irq)
        else $error("irq dropped without acknowledge");
endmodule
bind rfsi_status_irq rfsi_status_irq_chk chk_u (.clk(clk), .srst(srst), .enable(enable),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .tx_start(tx_start), .tx_end(tx_end), .rx_end(rx_end), .decoder_enable(decoder_enable));

// ===== testbench/tb_rf_status_irq_block.sv
// self-checking bench for the status and interrupt block
`timescale 1ns/10ps
module tb_rf_status_irq_block;
    localparam [44:0] EVK = {5'd4, 5'd5, 5'd7, 5'd8, 5'd6, 5'd11, 5'd12, 5'd13, 5'd14};
    reg        clk = 1'b0;
    reg        srst = 1'b1;
    reg        enable = 1'b1;
    reg        nfc = 1'b0;
    reg [16:0] pul = 17'h00000;
    reg [2:0]  lvl_m = 3'h5;
    reg [2:0]  lvl_a = 3'h3;
    reg [7:0]  d;
    wire [5:0] addr;
    wire [7:0] wdata;
    wire [7:0] rdata;
    wire       wr;
    wire       rd;
    wire       irq;
    wire       dec_en;
    integer    bad_count = 0;
    integer    cmp_count = 0;
    integer    i;
    integer    j;
    always #2 clk = ~clk;
    rfsi_host_model host_u (.clk(clk), .reg_rdata(rdata), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd));
    rfsi_status_irq #(.OSC_SETTLE_CYC(20)) dut_u (.clk(clk), .srst(srst), .enable(enable),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .irq(irq), .nfc_mode(nfc), .type_a_mode(1'b1), .tx_start(pul[0]), .tx_end(pul[1]),
        .rx_sof(pul[2]), .rx_end(pul[3]), .fifo_level_event(pul[4]), .crc_error(pul[5]),
        .protocol_error(pul[6]), .parity_error(pul[7]), .framing_error(pul[8]),
        .subcarrier_pulses(4'h0), .bit_period_end(pul[16]), .no_response_timeout(pul[9]),
        .next_slot_ready(pul[10]), .sdd_done(pul[11]), .field_change(pul[12]),
        .col_avoid_done(pul[13]), .col_avoid_fail(pul[14]), .error_event(pul[15]),
        .error_bit_pos(10'h000), .main_receive_input(lvl_m), .aux_receive_input(lvl_a),
        .decoder_enable(dec_en));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input [7:0] got, input [7:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task pls(input integer k);
        @(posedge clk);
        pul[k] <= 1'b1;
        @(posedge clk);
        pul[k] <= 1'b0;
    endtask
    task wirq;
        for (i = 0; i < 16 && irq !== 1'b1; i = i + 1)
            @(posedge clk);
        chk({7'h00, irq}, 8'h01);
        if (irq !== 1'b1)
            give_verdict;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        host_u.rd(6'h0D, d);
        chk(d, 8'h3E);
        host_u.rd(6'h0C, d);
        chk(d, 8'h00);
        host_u.rd(6'h0E, d);
        chk(d, 8'h00);
        host_u.rd(6'h3F, d);
        chk(d, 8'h00);
        pls(0);
        @(negedge clk);
        chk({6'h00, irq, dec_en}, 8'h00);
        pls(5);
        pls(1);
        wirq;
        host_u.rd(6'h0C, d);
        chk(d, 8'h80);
        pls(2);
        pls(3);
        wirq;
        host_u.rd(6'h0C, d);
        chk(d, 8'h40);
        host_u.rd(6'h0F, d);
        chk(d, 8'h5D);
        // fifo bit and reader error bits first, then the field mode meanings of the low five bits
        for (j = 0; j < 9; j = j + 1) begin
            nfc <= (j > 3);
            if (j == 8)
                host_u.wr(6'h0D, 8'h3F);
            pls(EVK[44 - 5 * j -: 5]);
            wirq;
            host_u.rd(6'h0C, d);
            chk(d, j < 4 ? 8'h20 >> j : 8'h10 >> (j - 4));
            @(posedge clk);
            chk({7'h00, irq}, 8'h00);
        end
        nfc <= 1'b0;
        host_u.wr(6'h0D, 8'h3E);
        host_u.rd(6'h0D, d);
        chk(d, 8'h3E);
        pls(9);
        repeat (4) @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        host_u.rd(6'h0C, d);
        chk(d, 8'h01);
        pls(7);
        wirq;
        host_u.wr(6'h01, 8'h00);
        host_u.rd(6'h0C, d);
        chk(d, 8'h00);
        pls(7);
        wirq;
        enable <= 1'b0;
        repeat (2) @(posedge clk);
        enable <= 1'b1;
        @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        host_u.rd(6'h0C, d);
        chk(d, 8'h00);
        give_verdict;
    end
endmodule
